// ### ebrwc_bus_ctrl.sv
// external bus cycle sequencer with ready-controlled access phase
// How it works
// RULE1: read data latched on the edge that ends read strobe and moves address.
// RULE2: captured data comes from the latch, unaffected by early address moves.
// RULE3: external module may drop data after strobe rises; nothing samples later.
// RULE4: readyActHigh selects active high or active low ready.
// RULE5: sync mode samples ready pin directly; module drives it on reference clock.
// RULE6: async mode routes ready through a synchroniser, adding two wait states.
// RULE7: async ready must stay active one clock period plus setup.
// RULE8: module may drop ready after the acknowledged strobe rises.
// RULE9: module removes ready before next ready cycle's first sample point.
// RULE10: inactive ready at sample point inserts one wait state, sample again.
// RULE11: active ready at sample point ends access phase.
// RULE12: async sample point is two cycles later than sync.
// RULE13: programmed access waits complete before ready is looked at.
// RULE14: each cycle runs address, command delay, write setup, access, hold.
// RULE15: only the access phase stretches with ready.
// RULE16: reference clock output follows the system clock.
// RULE17: async ready uses two flops then polarity correction.
// RULE18: after reset idle, strobes inactive, counter cleared.
`include "ebrwc_params.svh"
`timescale 1ns/100ps
`default_nettype none
module ebrwc_bus_ctrl
  import ebrwc_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          srst,
  input  wire ebrwc_timing_t timingCfg,
  input  wire logic          reqValid,
  input  wire ebrwc_req_t    req,
  input  wire logic          readyPin,
  input  wire logic [15:0]   dataIn,
  output var  logic          reqReady,
  output var  logic          busRefClkEn,
  output var  logic          rdStrobeN,
  output var  logic          wrStrobeN,
  output var  logic          csN,
  output var  logic          highByteEnableN,
  output var  logic [23:0]   addrOut,
  output var  logic [15:0]   dataOut,
  output var  logic          dataOutEn,
  output var  logic [15:0]   readData,
  output var  logic          doneValid,
  output var  logic          waitActive
);
  ebrwc_state_t  state;
  ebrwc_timing_t cfg;
  ebrwc_req_t    cur;
  logic [5:0]    phaseCnt;
  logic [5:0]    next_phaseCnt;
  logic          readySync;
  logic          readySample;
  logic          accessDone;

  ebrwc_ready_sync uSync (
    .mclk       (mclk),
    .srst       (srst),
    .readyPin   (readyPin),
    .activeHigh (cfg.readyActHigh),
    .readySync  (readySync)
  );

  // sync path samples pin directly for the shortest cycle
  always_comb begin
    if (cfg.readyAsync)
      readySample = readySync; // RULE6 RULE12
    else
      readySample = cfg.readyActHigh ? readyPin : ~readyPin; // RULE4 RULE5
  end

  // mandatory waits first, then ready decides
  always_comb begin
    accessDone = 1'b0;
    if (phaseCnt <= `EBRWC_CNT_ONE) begin // RULE13
      if (!cfg.readyEn)
        accessDone = 1'b1;
      else
        accessDone = readySample; // RULE10 RULE11 RULE15
    end
  end

  always_comb begin
    next_phaseCnt = (phaseCnt > `EBRWC_CNT_ONE) ? phaseCnt - `EBRWC_CNT_ONE : `EBRWC_CNT_ZERO;
  end

  // phase sequencing
  always_ff @(posedge mclk) begin
    if (srst) begin
      state    <= EBRWC_IDLE; // RULE18
      phaseCnt <= `EBRWC_CNT_ZERO;
      cfg      <= '0;
      cur      <= '0;
    end else begin
      case (state)
        EBRWC_IDLE: begin
          if (reqValid) begin
            cfg      <= timingCfg;
            cur      <= req;
            state    <= EBRWC_ADDR; // RULE14
            phaseCnt <= {3'h0, (timingCfg.addrSetup < `EBRWC_AB_MIN) ?
                         `EBRWC_AB_MIN : timingCfg.addrSetup};
          end
        end
        EBRWC_ADDR: begin
          if (phaseCnt <= `EBRWC_CNT_ONE) begin
            state    <= EBRWC_CMD;
            phaseCnt <= {4'h0, cfg.cmdDelay};
          end else
            phaseCnt <= next_phaseCnt;
        end
        EBRWC_CMD: begin
          if (phaseCnt == `EBRWC_CNT_ZERO || phaseCnt == `EBRWC_CNT_ONE) begin
            state    <= EBRWC_WSETUP;
            phaseCnt <= {5'h00, cfg.wrSetup};
          end else
            phaseCnt <= next_phaseCnt;
        end
        EBRWC_WSETUP: begin
          if (phaseCnt <= `EBRWC_CNT_ONE) begin
            state    <= EBRWC_ACCESS;
            phaseCnt <= cfg.accessLen;
          end else
            phaseCnt <= next_phaseCnt;
        end
        EBRWC_ACCESS: begin
          if (accessDone) begin // RULE11
            state    <= EBRWC_HOLD;
            phaseCnt <= {4'h0, cfg.holdLen};
          end else
            phaseCnt <= next_phaseCnt; // RULE10
        end
        EBRWC_HOLD: begin
          if (phaseCnt <= `EBRWC_CNT_ONE) begin
            state    <= EBRWC_IDLE;
            phaseCnt <= `EBRWC_CNT_ZERO;
          end else
            phaseCnt <= next_phaseCnt;
        end
        default: state <= EBRWC_IDLE;
      endcase
    end
  end

  // strobes, address and chip select
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdStrobeN       <= 1'b1; // RULE18
      wrStrobeN       <= 1'b1;
      csN             <= 1'b1;
      highByteEnableN <= 1'b1;
      addrOut         <= `EBRWC_ADDR_ZERO;
      dataOut         <= `EBRWC_DATA_ZERO;
      dataOutEn       <= 1'b0;
    end else begin
      if (state == EBRWC_IDLE && reqValid) begin
        csN             <= 1'b0;
        addrOut         <= req.addr;
        highByteEnableN <= ~req.highByte;
        dataOut         <= req.wdata;
        dataOutEn       <= req.write;
      end
      if (state == EBRWC_CMD && phaseCnt <= `EBRWC_CNT_ONE) begin
        rdStrobeN <= cur.write;
        wrStrobeN <= ~cur.write;
      end
      // strobe rise and address release share this edge with the capture
      if (state == EBRWC_ACCESS && accessDone) begin
        rdStrobeN <= 1'b1; // RULE1
        wrStrobeN <= 1'b1;
        if (!cur.write)
          addrOut <= `EBRWC_ADDR_ZERO; // RULE1
      end
      if (state == EBRWC_HOLD && phaseCnt <= `EBRWC_CNT_ONE) begin
        csN             <= 1'b1;
        highByteEnableN <= 1'b1;
        dataOutEn       <= 1'b0;
      end
    end
  end

  // read capture only at strobe end; bus is never looked at after
  always_ff @(posedge mclk) begin
    if (srst) begin
      readData  <= `EBRWC_DATA_ZERO;
      doneValid <= 1'b0;
    end else begin
      doneValid <= 1'b0;
      if (state == EBRWC_ACCESS && accessDone) begin
        doneValid <= 1'b1;
        if (!cur.write)
          readData <= dataIn; // RULE1 RULE2 RULE3
      end
    end
  end

  // status and handshake outputs
  always_ff @(posedge mclk) begin
    if (srst) begin
      reqReady    <= 1'b0;
      waitActive  <= 1'b0;
      busRefClkEn <= 1'b0;
    end else begin
      reqReady    <= (state == EBRWC_IDLE) && !reqValid;
      waitActive  <= (state == EBRWC_ACCESS) && !accessDone;
      busRefClkEn <= 1'b1; // RULE16
    end
  end

  a_access_gate: assert property (@(posedge mclk) disable iff (srst) // RULE13
    (state == EBRWC_ACCESS && phaseCnt > `EBRWC_CNT_ONE) |=> state == EBRWC_ACCESS)
    else $error("access left before mandatory waits");
  a_ready_ends: assert property (@(posedge mclk) disable iff (srst) // RULE11
    (state == EBRWC_ACCESS && phaseCnt <= `EBRWC_CNT_ONE && cfg.readyEn && readySample)
    |=> state == EBRWC_HOLD && rdStrobeN && wrStrobeN)
    else $error("ready did not end access");
  a_not_ready_wait: assert property (@(posedge mclk) disable iff (srst) // RULE10
    (state == EBRWC_ACCESS && cfg.readyEn && !readySample) |=> state == EBRWC_ACCESS)
    else $error("wait state not inserted");
  a_read_capture: assert property (@(posedge mclk) disable iff (srst) // RULE1
    (state == EBRWC_ACCESS && accessDone && !cur.write) |=> readData == $past(dataIn))
    else $error("read data not latched at strobe end");
  a_data_stable: assert property (@(posedge mclk) disable iff (srst) // RULE2
    (state != EBRWC_ACCESS) |=> $stable(readData))
    else $error("read data changed outside capture");
  // async sample must be the pin as it stood two edges back
  a_async_path: assert property (@(posedge mclk) disable iff (srst) // RULE6 RULE17
    (cfg.readyAsync && state == EBRWC_ACCESS)
    |-> readySample == ($past(readyPin, 2) ~^ cfg.readyActHigh))
    else $error("async ready bypassed synchroniser");
  a_polarity_sync: assert property (@(posedge mclk) disable iff (srst) // RULE4
    (!cfg.readyAsync) |-> readySample == (readyPin ~^ cfg.readyActHigh))
    else $error("ready polarity wrong");
  a_reset_idle: assert property (@(posedge mclk) // RULE18
    srst |=> state == EBRWC_IDLE && rdStrobeN && wrStrobeN && phaseCnt == `EBRWC_CNT_ZERO)
    else $error("not idle after reset");
endmodule // ebrwc_bus_ctrl
`default_nettype wire

// ### ebrwc_params.svh
// constants for the external bus ready wait control block
`ifndef EBRWC_PARAMS_SVH
`define EBRWC_PARAMS_SVH
`define EBRWC_CLK_PERIOD_NS   50
`define EBRWC_AB_MIN          3'h1
`define EBRWC_CNT_ZERO        6'h00
`define EBRWC_CNT_ONE         6'h01
`define EBRWC_DATA_ZERO       16'h0000
`define EBRWC_ADDR_ZERO       24'h000000
`endif

// ### ebrwc_pkg.sv
// types for the external bus ready wait control block
`default_nettype none
package ebrwc_pkg;
  typedef enum logic [2:0] {
    EBRWC_IDLE,
    EBRWC_ADDR,
    EBRWC_CMD,
    EBRWC_WSETUP,
    EBRWC_ACCESS,
    EBRWC_HOLD
  } ebrwc_state_t;

  // per chip-select phase programming
  typedef struct packed {
    logic [2:0] addrSetup;   // 1..5
    logic [1:0] cmdDelay;    // 0..3
    logic       wrSetup;     // 0..1
    logic [5:0] accessLen;   // 1..32
    logic [1:0] holdLen;     // 0..3
    logic       readyEn;
    logic       readyAsync;
    logic       readyActHigh;
  } ebrwc_timing_t;

  typedef struct packed {
    logic        write;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic        highByte;
  } ebrwc_req_t;
endpackage
`default_nettype wire

// ### ebrwc_ready_sync.sv
// two-flop ready synchroniser with polarity correction
`timescale 1ns/100ps
`default_nettype none
module ebrwc_ready_sync (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic readyPin,
  input  wire logic activeHigh,
  output var  logic readySync
);
  logic stage1;
  logic stage2;

  always_ff @(posedge mclk) begin
    if (srst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      stage1 <= readyPin; // RULE17
      stage2 <= stage1;
    end
  end

  // polarity applied after the chain, so stage1 feeds only stage2
  always_comb begin
    readySync = activeHigh ? stage2 : ~stage2; // RULE17
  end
endmodule // ebrwc_ready_sync
`default_nettype wire

// ### ebrwc_ext_model.sv
// external memory model answering with ready and read data
`timescale 1ns/100ps
`default_nettype none
module ebrwc_ext_model (
  input  wire logic        mclk,
  input  wire logic        rdStrobeN,
  input  wire logic        wrStrobeN,
  input  wire logic        activeHigh,
  input  wire logic [5:0]  waitCycles,
  input  wire logic [15:0] memWord,
  output var  logic        readyPin,
  output var  logic [15:0] dataIn
);
  logic [5:0]  waitCnt = 6'h00;
  logic        rdy     = 1'b0;
  logic [15:0] junk    = 16'hFFFF;
  always @(posedge mclk) begin
    // ready leaves once the strobe rises, so the next cycle starts clean
    if (rdStrobeN && wrStrobeN) begin
      waitCnt <= #1 6'h00;
      rdy     <= #1 1'b0;
    end else begin
      waitCnt <= #1 waitCnt + 6'h01;
      rdy     <= #1 (waitCnt >= waitCycles);
    end
    junk <= #1 ~junk;
  end
  assign readyPin = activeHigh ? rdy : ~rdy;
  // data gone once the strobe rises; junk changes every cycle
  assign dataIn = rdStrobeN ? junk : memWord;
endmodule // ebrwc_ext_model
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the bus cycle sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import ebrwc_pkg::*;
  logic          mclk, srst, reqValid, readyPin, reqReady, refEn, rdN, wrN, csN;
  logic          outEn, doneValid, waitActive, sawWait, hbeN, hbeSeen;
  logic [5:0]    waitCycles;
  logic [15:0]   memWord, dataIn, dataOut, readData, wrSeen;
  logic [23:0]   addrOut, addrSeen;
  ebrwc_timing_t cfg;
  ebrwc_req_t    req;
  int            num_errors, check_count, dur, d0, d1;

  ebrwc_bus_ctrl ebrwc_bus_ctrl_inst (.mclk(mclk), .srst(srst), .timingCfg(cfg),
    .reqValid(reqValid), .req(req), .readyPin(readyPin), .dataIn(dataIn),
    .reqReady(reqReady), .busRefClkEn(refEn), .rdStrobeN(rdN), .wrStrobeN(wrN),
    .csN(csN), .highByteEnableN(hbeN), .addrOut(addrOut), .dataOut(dataOut),
    .dataOutEn(outEn), .readData(readData), .doneValid(doneValid),
    .waitActive(waitActive));
  ebrwc_ext_model ebrwc_ext_model_inst (.mclk(mclk), .rdStrobeN(rdN), .wrStrobeN(wrN),
    .activeHigh(cfg.readyActHigh), .waitCycles(waitCycles), .memWord(memWord),
    .readyPin(readyPin), .dataIn(dataIn));

  task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_gap(input int got, input int exp);
    check_val(24'(got), 24'(exp));
  endtask
  task automatic summarize();
    $display("errors %0d, checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one bus cycle; dur counts edges from take to the done pulse
  task automatic run(input logic wr, input logic [15:0] wd);
    int k;
    k = 0;
    while (reqReady !== 1'b1 && k < 100) begin
      @(posedge mclk);
      #1;
      k++;
    end
    reqValid = 1'b1;
    req = '{write: wr, addr: 24'h01F2A4, wdata: wd, highByte: 1'b1};
    @(posedge mclk);
    #1;
    reqValid = 1'b0;
    dur = 0;
    sawWait = 1'b0;
    while (doneValid !== 1'b1 && dur < 200) begin
      @(posedge mclk);
      #1;
      dur++;
      if (wrN === 1'b0) wrSeen = outEn ? dataOut : 16'h0000;
      if (waitActive === 1'b1) sawWait = 1'b1;
      if (rdN === 1'b0) addrSeen = addrOut;
      if (csN === 1'b0) hbeSeen = hbeN;
    end
    // a bounded wait that runs out is a failure of its own
    if (k >= 100 || dur >= 200) num_errors++;
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    #400000;
    num_errors++;
    summarize();
  end
  initial begin
    srst = 1'b1;
    reqValid = 1'b0;
    req = '0;
    memWord = 16'h5A3C;
    waitCycles = 6'h03;
    cfg = '{addrSetup: 3'h2, cmdDelay: 2'h1, wrSetup: 1'b0, accessLen: 6'h02,
      holdLen: 2'h1, readyEn: 1'b1, readyAsync: 1'b0, readyActHigh: 1'b1};
    repeat (20) @(posedge mclk);
    #1;
    check_val(rdN & wrN & csN, 24'h000001);
    check_val(doneValid | waitActive, 24'h000000);
    srst = 1'b0;
    @(posedge mclk);
    #1;
    check_val(refEn, 24'h000001);
    run(1'b0, 16'h0000);
    d0 = dur;
    check_val(readData, 24'h005A3C);
    check_val(addrSeen, 24'h01F2A4);
    check_val(hbeSeen, 24'h000000);
    check_val(addrOut, 24'h000000);
    // both ready polarities must give the same cycle length
    for (int p = 0; p < 2; p++) begin
      cfg.readyActHigh = p[0];
      run(1'b0, 16'h0000);
      check_gap(dur, d0);
    end
    waitCycles = 6'h06;
    run(1'b0, 16'h0000);
    check_gap(dur - d0, 3);
    check_val(sawWait, 24'h000001);
    waitCycles = 6'h03;
    // fresh word so a missed capture cannot hide behind the old one
    memWord = 16'hA5C3;
    cfg.readyAsync = 1'b1;
    run(1'b0, 16'h0000);
    check_gap(dur - d0, 2);
    check_val(readData, 24'h00A5C3);
    cfg.readyAsync = 1'b0;
    waitCycles = 6'h00;
    cfg.accessLen = 6'h08;
    run(1'b0, 16'h0000);
    d1 = dur;
    cfg.readyEn = 1'b0;
    run(1'b0, 16'h0000);
    check_gap(dur, d1);
    d1 = dur;
    cfg.addrSetup = 3'h3;
    cfg.cmdDelay = 2'h2;
    run(1'b1, 16'hC35A);
    check_gap(dur - d1, 2);
    check_val(wrSeen, 24'h00C35A);
    // reset in mid-cycle must drop strobe and chip select within two edges
    repeat (3) @(posedge mclk);
    #1;
    reqValid = 1'b1;
    @(posedge mclk);
    #1;
    reqValid = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    check_val({wrN, csN}, 24'h000000);
    srst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check_val(rdN & wrN & csN, 24'h000001);
    check_val(doneValid | waitActive, 24'h000000);
    srst = 1'b0;
    run(1'b0, 16'h0000);
    check_val(readData, 24'h00A5C3);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
